// [include/rtc_irq_pkg.sv]
package rtc_irq_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL = 4'hE;
	localparam logic [3:0] ADDR_STAT = 4'hF;

	localparam int BIT_WEEKDAY_EN = 7;
	localparam int BIT_DAILY_EN   = 6;
	localparam int PSEL_LSB       = 0;
	localparam int PSEL_W         = 3;
	localparam int BIT_PFLAG      = 2;
	localparam int BIT_WFLAG      = 1;
	localparam int BIT_DFLAG      = 0;

	localparam logic       EN_RST   = 1'b0;
	localparam logic [2:0] PSEL_RST = 3'h0;
	localparam logic       FLAG_RST = 1'b0;

	typedef enum logic [PSEL_W-1:0] {
		PS_OFF, PS_LOW, PS_2HZ, PS_1HZ, PS_SEC, PS_MIN, PS_HOUR, PS_MONTH
	} psel_t;

	// ------------------------------------------------------------
	// timebase and timing
	// ------------------------------------------------------------
	localparam longint TB_HZ        = 32768;
	localparam int     TB_BITS      = 15;
	localparam int     BIT_HALF_SEC = 14;
	localparam int     BIT_QTR_SEC  = 13;

	localparam longint INC_DELAY_NS    = 92000;
	localparam int     INC_DELAY_RAW   = int'((INC_DELAY_NS * TB_HZ) / 64'd1000000000);
	localparam int     INC_DELAY_TICKS = (INC_DELAY_RAW < 1) ? 1 : INC_DELAY_RAW;
	localparam int     DLY_W           = 3;

	localparam longint ADJ_MAX_US     = 3784;
	localparam int     ADJ_MAX_TICKS  = int'((ADJ_MAX_US * TB_HZ) / 64'd1000000);
	localparam int     ADJ_INTERVAL_S = 20;

	localparam logic [7:0] BCD_SEC_LAST  = 8'h59;
	localparam logic [7:0] BCD_MIN_LAST  = 8'h59;
	localparam logic [7:0] BCD_HOUR_LAST = 8'h23;

endpackage

// [rtl/sub_second_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module sub_second_divider #(
	parameter int ADJ_INTERVAL = rtc_irq_pkg::ADJ_INTERVAL_S
) (
	input  wire logic                              ref_clk,
	input  wire logic                              srst,
	input  wire logic                              tb_tick,
	input  wire logic                              restart,
	input  wire logic                              adj_active,
	input  wire logic signed [7:0]                 adj_ticks,
	output logic        [rtc_irq_pkg::TB_BITS-1:0] phase_r,
	output logic                                   wrap_r,
	output logic                                   sec_inc_r
);
	import rtc_irq_pkg::*;

	localparam int SW = $clog2(ADJ_INTERVAL);

	logic [6:0]       slip_r;
	logic [SW-1:0]    win_r;
	logic [DLY_W-1:0] dly_r;

	wire logic       at_top  = (&phase_r) && (slip_r == 7'h00);
	wire logic       roll    = tb_tick && at_top;
	wire logic       adj_sec = adj_active && (win_r == SW'(ADJ_INTERVAL - 1));
	wire logic [7:0] mag_raw = adj_ticks[7] ? 8'($unsigned(-adj_ticks)) : $unsigned(adj_ticks);
	wire logic [6:0] mag     = (mag_raw > 8'(ADJ_MAX_TICKS)) ? 7'(ADJ_MAX_TICKS) : mag_raw[6:0];

	// ------------------------------------------------------------
	// phase counter; the adjusted second pauses or skips at phase 0
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst || restart) begin
			phase_r <= '0;
			slip_r  <= 7'h00;
		end else if (tb_tick) begin
			if (slip_r != 7'h00) begin
				slip_r <= slip_r - 7'h01;
			end else if (at_top && adj_sec && !adj_ticks[7]) begin
				phase_r <= '0;
				slip_r  <= mag;
			end else if (at_top && adj_sec) begin
				phase_r <= TB_BITS'(mag);
			end else begin
				phase_r <= TB_BITS'(phase_r + 1'b1);
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst || restart) begin
			win_r <= '0;
		end else if (roll) begin
			win_r <= adj_sec ? '0 : SW'(win_r + 1'b1);
		end
	end

	// ------------------------------------------------------------
	// second increment trails the falling edge by a few ticks
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst || restart) begin
			dly_r <= '0;
		end else if (roll) begin
			dly_r <= DLY_W'(INC_DELAY_TICKS);
		end else if (tb_tick && dly_r != '0) begin
			dly_r <= dly_r - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		wrap_r    <= !srst && (restart || roll);
		sec_inc_r <= !srst && !restart && tb_tick && (dly_r == DLY_W'(1));
	end

endmodule
`default_nettype wire

// [rtl/rtc_alarm_periodic_irq.sv]
// Behaviour
// - weekday, hour, minute match with weekday alarm enabled pulls pin B low
// - daily alarm (hour, minute) drives pin A; flags tell it from periodic
// - periodic output only on pin A, pulse or level per select bits
// - status register holds periodic D2, weekday D1, daily D0 flags
// - control register holds weekday enable D7, daily D6, select D2..D0
// - select code zero disables periodic source, pin A contribution released
// - all enables and select zero after power-on release both pins
// - shared pin is low whenever any of its sources asserts
// - alarm enable one lets the alarm drive its pin, zero disables it
// - flag reads show alarm state; write one no effect, zero clears
// - clearing a flag keeps its enable, alarm re-arms for next match
// - codes 010 and 011 give 2 Hz and 1 Hz half-duty pulses
// - codes 100..111 fire each second, minute, hour, month start
// - level mode sets periodic flag and holds pin A low until cleared
// - periodic falling edge aligned with divider wrap, ahead of second counter increment
// - adjustment stretches or shrinks one second per 20 by at most 3.784 ms
// - second increment lags the pulse falling edge by about 92 us
// - second write resets sub-second divider and, with code 010 or 011 selected, drives pin A low
// - oscillation halt clears enables, select field and all three flags
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_periodic_irq (
	input  wire logic              ref_clk,
	input  wire logic              srst,
	input  wire logic              tb_tick,
	input  wire logic [3:0]        reg_addr,
	input  wire logic              reg_wr,
	input  wire logic [7:0]        reg_wdata,
	output logic      [7:0]        reg_rdata,
	input  wire logic              sec_write,
	input  wire logic              osc_halt_flag,
	input  wire logic              adj_active,
	input  wire logic signed [7:0] adj_ticks,
	input  wire logic [7:0]        cur_second,
	input  wire logic [7:0]        cur_minute,
	input  wire logic [7:0]        cur_hour,
	input  wire logic [2:0]        cur_weekday,
	input  wire logic              last_day,
	input  wire logic [6:0]        alarm_w_days,
	input  wire logic [7:0]        alarm_w_hour,
	input  wire logic [7:0]        alarm_w_minute,
	input  wire logic [7:0]        alarm_d_hour,
	input  wire logic [7:0]        alarm_d_minute,
	input  wire logic              irq_pin_a_i,
	output logic                   irq_pin_a_o,
	output logic                   irq_pin_a_oe,
	input  wire logic              irq_pin_b_i,
	output logic                   irq_pin_b_o,
	output logic                   irq_pin_b_oe,
	output logic                   sec_inc
);
	import rtc_irq_pkg::*;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic time_match(
		input logic [7:0] h,
		input logic [7:0] m,
		input logic [7:0] ah,
		input logic [7:0] am
	);
		time_match = (h == ah) && (m == am);
	endfunction

	function automatic logic is_pulse(input psel_t p);
		is_pulse = (p == PS_2HZ) || (p == PS_1HZ);
	endfunction

	function automatic logic is_level(input psel_t p);
		is_level = p[PSEL_W-1];
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic                   wk_en_r;
	logic                   dy_en_r;
	psel_t                  psel_r;
	logic                   pflag_r;
	logic                   wflag_r;
	logic                   dflag_r;
	logic                   wmatch_prev_r;
	logic                   dmatch_prev_r;
	logic                   lo_prev_r;
	logic [TB_BITS-1:0]     phase;
	logic                   wrap;
	logic                   wk_en_nxt;
	logic                   dy_en_nxt;
	psel_t                  psel_nxt;
	logic                   pflag_nxt;
	logic                   wflag_nxt;
	logic                   dflag_nxt;
	logic                   pin_a_nxt;
	logic                   pin_b_nxt;
	logic [7:0]             rdata_nxt;

	// ------------------------------------------------------------
	// sub-second divider
	// ------------------------------------------------------------
	sub_second_divider #(
		.ADJ_INTERVAL (ADJ_INTERVAL_S)
	) u_div (
		.ref_clk    (ref_clk),
		.srst       (srst),
		.tb_tick    (tb_tick),
		.restart    (sec_write),
		.adj_active (adj_active),
		.adj_ticks  (adj_ticks),
		.phase_r    (phase),
		.wrap_r     (wrap),
		.sec_inc_r  (sec_inc)
	);

	// ------------------------------------------------------------
	// register access decode
	// ------------------------------------------------------------
	wire logic wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
	wire logic wr_stat = reg_wr && (reg_addr == ADDR_STAT);

	wire logic clr_pflag = wr_stat && !reg_wdata[BIT_PFLAG];
	wire logic clr_wflag = wr_stat && !reg_wdata[BIT_WFLAG];
	wire logic clr_dflag = wr_stat && !reg_wdata[BIT_DFLAG];

	// ------------------------------------------------------------
	// alarm compare, first-match detect on the timebase tick
	// ------------------------------------------------------------
	wire logic day_hit = (cur_weekday < 3'h7) && alarm_w_days[cur_weekday];
	wire logic wmatch  = day_hit &&
		time_match(cur_hour, cur_minute, alarm_w_hour, alarm_w_minute);
	wire logic dmatch  =
		time_match(cur_hour, cur_minute, alarm_d_hour, alarm_d_minute);

	wire logic wset = tb_tick && wmatch && !wmatch_prev_r;
	wire logic dset = tb_tick && dmatch && !dmatch_prev_r;

	// ------------------------------------------------------------
	// periodic source
	// ------------------------------------------------------------
	wire logic pulse_lo = (psel_r == PS_2HZ) ?
		!phase[BIT_QTR_SEC] : !phase[BIT_HALF_SEC];
	wire logic pulse_fall = is_pulse(psel_r) && pulse_lo && !lo_prev_r;

	wire logic roll_sec  = (cur_second == BCD_SEC_LAST);
	wire logic roll_min  = roll_sec && (cur_minute == BCD_MIN_LAST);
	wire logic roll_hour = roll_min && (cur_hour == BCD_HOUR_LAST);

	logic period_hit;
	always_comb begin
		case (psel_r)
			PS_SEC:   period_hit = 1'b1;
			PS_MIN:   period_hit = roll_sec;
			PS_HOUR:  period_hit = roll_min;
			PS_MONTH: period_hit = roll_hour && last_day;
			default:  period_hit = 1'b0;
		endcase
	end

	// falling edge of a level period lands on the divider wrap
	wire logic lvl_evt = wrap && is_level(psel_r) && period_hit;
	wire logic pset    = lvl_evt || pulse_fall;

	// ------------------------------------------------------------
	// next state: halt clears last and wins, a new event beats a clear
	// ------------------------------------------------------------
	always_comb begin
		wk_en_nxt = wk_en_r;
		dy_en_nxt = dy_en_r;
		psel_nxt  = psel_r;
		if (wr_ctrl) begin
			wk_en_nxt = reg_wdata[BIT_WEEKDAY_EN];
			dy_en_nxt = reg_wdata[BIT_DAILY_EN];
			psel_nxt  = psel_t'(reg_wdata[PSEL_LSB +: PSEL_W]);
		end
		pflag_nxt = pset || (pflag_r && !clr_pflag);
		wflag_nxt = wset || (wflag_r && !clr_wflag);
		dflag_nxt = dset || (dflag_r && !clr_dflag);
		if (osc_halt_flag) begin
			wk_en_nxt = EN_RST;
			dy_en_nxt = EN_RST;
			psel_nxt  = psel_t'(PSEL_RST);
			pflag_nxt = FLAG_RST;
			wflag_nxt = FLAG_RST;
			dflag_nxt = FLAG_RST;
		end
	end

	// ------------------------------------------------------------
	// pin drive, open drain: enable high pulls the wire low
	// ------------------------------------------------------------
	logic per_lo_nxt;
	always_comb begin
		case (psel_nxt)
			PS_OFF:  per_lo_nxt = 1'b0;
			PS_LOW:  per_lo_nxt = 1'b1;
			PS_2HZ,
			PS_1HZ:  per_lo_nxt = pulse_lo;
			default: per_lo_nxt = pflag_nxt;
		endcase
	end

	assign pin_a_nxt = per_lo_nxt || (dflag_nxt && dy_en_nxt);
	assign pin_b_nxt = wflag_nxt && wk_en_nxt;

	assign rdata_nxt =
		(reg_addr == ADDR_CTRL) ? {wk_en_r, dy_en_r, 3'h0, psel_r} :
		(reg_addr == ADDR_STAT) ? {5'h00, pflag_r, wflag_r, dflag_r} :
		8'h00;

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wk_en_r <= EN_RST;
			dy_en_r <= EN_RST;
			psel_r  <= psel_t'(PSEL_RST);
			pflag_r <= FLAG_RST;
			wflag_r <= FLAG_RST;
			dflag_r <= FLAG_RST;
		end else begin
			wk_en_r <= wk_en_nxt;
			dy_en_r <= dy_en_nxt;
			psel_r  <= psel_nxt;
			pflag_r <= pflag_nxt;
			wflag_r <= wflag_nxt;
			dflag_r <= dflag_nxt;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wmatch_prev_r <= 1'b0;
			dmatch_prev_r <= 1'b0;
		end else if (tb_tick) begin
			wmatch_prev_r <= wmatch;
			dmatch_prev_r <= dmatch;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			lo_prev_r    <= 1'b1;
			irq_pin_a_oe <= 1'b0;
			irq_pin_b_oe <= 1'b0;
			irq_pin_a_o  <= 1'b0;
			irq_pin_b_o  <= 1'b0;
			reg_rdata    <= 8'h00;
		end else begin
			lo_prev_r    <= pulse_lo;
			irq_pin_a_oe <= pin_a_nxt;
			irq_pin_b_oe <= pin_b_nxt;
			irq_pin_a_o  <= 1'b0;
			irq_pin_b_o  <= 1'b0;
			reg_rdata    <= rdata_nxt;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence s_restart_pulse;
		sec_write && is_pulse(psel_r) && !wr_ctrl && !osc_halt_flag;
	endsequence

	sequence s_phase_low;
		!wr_ctrl && !osc_halt_flag ##1 !wr_ctrl && !osc_halt_flag;
	endsequence

	chk_pin_b_alarm: assert property (
		!$past(srst) |-> irq_pin_b_oe == $past(wflag_nxt && wk_en_nxt))
		else $error("pin B does not follow weekday flag and enable");

	chk_pin_a_daily: assert property (
		dflag_r && dy_en_r |-> irq_pin_a_oe)
		else $error("pin A released while daily alarm pending");

	chk_off_release: assert property (
		psel_r == PS_OFF && !(dflag_r && dy_en_r) |-> !irq_pin_a_oe)
		else $error("pin A low with periodic source off");

	chk_fixed_low: assert property (
		psel_r == PS_LOW |-> irq_pin_a_oe)
		else $error("pin A released while fixed low selected");

	chk_set_beats_clear: assert property (
		wset && clr_wflag && !osc_halt_flag |=> wflag_r)
		else $error("flag clear dropped a coincident alarm match");

	chk_write_one_idle: assert property (
		wr_stat && reg_wdata[BIT_WFLAG] && !wflag_r && !wset && !osc_halt_flag
		|=> !wflag_r)
		else $error("writing one changed the weekday flag");

	chk_clear_keeps_en: assert property (
		wr_stat && !wr_ctrl && !osc_halt_flag |=> wk_en_r == $past(wk_en_r)
		&& dy_en_r == $past(dy_en_r))
		else $error("status write disturbed an alarm enable");

	chk_match_sets: assert property (
		tb_tick && dmatch && !dmatch_prev_r && !osc_halt_flag |=> dflag_r)
		else $error("daily flag not set on first match");

	chk_level_hold: assert property (
		is_level(psel_r) && pflag_r && !clr_pflag && !osc_halt_flag
		|-> irq_pin_a_oe ##1 pflag_r)
		else $error("level interrupt released without a clear");

	chk_halt_clears: assert property (
		osc_halt_flag |=> !wk_en_r && !dy_en_r && psel_r == PS_OFF
		&& !pflag_r && !wflag_r && !dflag_r)
		else $error("oscillation halt left control or flags set");

	chk_restart_low: assert property (
		s_restart_pulse ##0 s_phase_low |-> ##2 irq_pin_a_oe)
		else $error("second write did not pull pin A low");

endmodule
`default_nettype wire

// [sim/irq_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module irq_host_model (
	input  wire logic oe_a,
	input  wire logic drv_a,
	input  wire logic oe_b,
	input  wire logic drv_b,
	output logic      pin_a,
	output logic      pin_b
);
	// ------------------------------------------------------------
	// host pull-ups: a released open-drain line reads high
	// ------------------------------------------------------------
	assign pin_a = oe_a ? drv_a : 1'b1;
	assign pin_b = oe_b ? drv_b : 1'b1;
endmodule
`default_nettype wire

// [sim/rtc_alarm_periodic_irq_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module rtc_alarm_periodic_irq_tb;
	import rtc_irq_pkg::*;
	typedef struct packed {int src; logic [7:0] v;} note_t;
	logic             ref_clk, srst, tb_tick, reg_wr, sec_write, osc_halt_flag;
	logic [3:0]       reg_addr;
	logic [7:0]       reg_wdata, reg_rdata, cur_second, cur_minute, cur_hour;
	logic [2:0]       cur_weekday, wd;
	logic             last_day, a_o, a_oe, b_o, b_oe, pin_a, pin_b, sec_inc;
	logic [6:0]       alarm_w_days;
	logic [7:0]       alarm_w_hour, alarm_w_minute, alarm_d_hour, alarm_d_minute;
	logic [7:0]       hr, mn, d, got;
	logic             chk_stb, pa_q, inc_ok;
	int               failures, cmp_count, cyc_n, since;
	note_t            exp_q[$];
	note_t            n;

	rtc_alarm_periodic_irq dut (
		.ref_clk       (ref_clk),
		.srst          (srst),
		.tb_tick       (tb_tick),
		.reg_addr      (reg_addr),
		.reg_wr        (reg_wr),
		.reg_wdata     (reg_wdata),
		.reg_rdata     (reg_rdata),
		.sec_write     (sec_write),
		.osc_halt_flag (osc_halt_flag),
		.adj_active    (1'b0),
		.adj_ticks     (8'sh00),
		.cur_second    (cur_second),
		.cur_minute    (cur_minute),
		.cur_hour      (cur_hour),
		.cur_weekday   (cur_weekday),
		.last_day      (last_day),
		.alarm_w_days  (alarm_w_days),
		.alarm_w_hour  (alarm_w_hour),
		.alarm_w_minute(alarm_w_minute),
		.alarm_d_hour  (alarm_d_hour),
		.alarm_d_minute(alarm_d_minute),
		.irq_pin_a_i   (pin_a),
		.irq_pin_a_o   (a_o),
		.irq_pin_a_oe  (a_oe),
		.irq_pin_b_i   (pin_b),
		.irq_pin_b_o   (b_o),
		.irq_pin_b_oe  (b_oe),
		.sec_inc       (sec_inc)
	);
	irq_host_model host (
		.oe_a (a_oe),
		.drv_a(a_o),
		.oe_b (b_oe),
		.drv_b(b_o),
		.pin_a(pin_a),
		.pin_b(pin_b)
	);

	// ------------------------------------------------------------
	// clock, timebase (one tick per cycle keeps a second short), timeout
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		tb_tick <= !srst;
		cyc_n++;
		if (cyc_n == 100000) begin
			failures++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// monitor: pairs each result with the oldest note
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		pa_q <= pin_a;
		if (pa_q && !pin_a) begin
			since <= 0;
			inc_ok <= 1'b0;
		end else begin
			since <= since + 1;
			if (sec_inc && since < 5) inc_ok <= 1'b1;
		end
	end
	always @(negedge ref_clk) begin
		if (chk_stb && exp_q.size() > 0) begin
			n = exp_q.pop_front();
			case (n.src)
				0: got = reg_rdata;
				1: got = {6'h00, pin_b, pin_a};
				default: got = {7'h00, inc_ok};
			endcase
			`CHECK(got, n.v)
		end
	end

	// ------------------------------------------------------------
	// driver tasks
	// ------------------------------------------------------------
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic chk(input int s, input logic [7:0] v);
		@(posedge ref_clk);
		exp_q.push_back('{s, v});
		chk_stb <= 1'b1;
		@(posedge ref_clk);
		chk_stb <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		chk(0, v);
	endtask
	task automatic sec_pulse();
		@(posedge ref_clk);
		sec_write <= 1'b1;
		@(posedge ref_clk);
		sec_write <= 1'b0;
	endtask
	// match drops for a few ticks, then returns
	task automatic rematch();
		@(posedge ref_clk);
		cur_minute <= 8'h7F;
		cyc(3);
		cur_minute <= mn;
		cyc(3);
	endtask
	task automatic wait_fall();
		int k;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pin_a !== 1'b0 && k < 40000);
		if (pin_a !== 1'b0) failures++;
	endtask
	task automatic done(input string s);
		$display("test %s done at %0t", s, $time);
	endtask
	task automatic finish_test();
		$display("TB: comparisons=%0d mismatches=%0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{srst, tb_tick, reg_wr, sec_write, osc_halt_flag, chk_stb, last_day} = 7'h41;
		{reg_addr, reg_wdata, cur_second, cur_weekday} = '0;
		{cur_minute, cur_hour, alarm_w_days} = {8'h7F, 8'h30, 7'h00};
		{alarm_w_hour, alarm_w_minute, alarm_d_hour, alarm_d_minute} = '0;
		{failures, cmp_count, cyc_n, since, pa_q, inc_ok} = '0;
		void'($urandom(32'h3b473f26));
		hr = {4'($urandom_range(0, 1)), 4'($urandom_range(0, 9))};
		mn = {4'($urandom_range(0, 5)), 4'($urandom_range(0, 9))};
		wd = 3'($urandom_range(0, 6));
		cyc(20);
		srst <= 1'b0;
		rd(ADDR_CTRL, 8'h00);
		rd(ADDR_STAT, 8'h00);
		rd(4'h3, 8'h00);
		chk(1, 8'h03);
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			wr(ADDR_CTRL, d);
			rd(ADDR_CTRL, d & 8'hC7);
		end
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_STAT, 8'h00);
		done("registers");
		// disable, program alarm time, then enable
		wr(ADDR_CTRL, 8'h00);
		alarm_d_hour <= hr;
		alarm_d_minute <= mn;
		wr(ADDR_CTRL, 8'h40);
		cur_hour <= hr;
		rematch();
		rd(ADDR_STAT, 8'h01);
		chk(1, 8'h02);
		wr(ADDR_STAT, 8'h07);
		rd(ADDR_STAT, 8'h01);
		wr(ADDR_STAT, 8'hFE);
		rd(ADDR_STAT, 8'h00);
		chk(1, 8'h03);
		rd(ADDR_CTRL, 8'h40);
		rematch();
		chk(1, 8'h02);
		wr(ADDR_CTRL, 8'h00);
		chk(1, 8'h03);
		wr(ADDR_STAT, 8'hFE);
		rematch();
		rd(ADDR_STAT, 8'h01);
		chk(1, 8'h03);
		done("daily alarm");
		alarm_w_days <= 7'(1 << wd);
		alarm_w_hour <= hr;
		alarm_w_minute <= mn;
		cur_weekday <= wd;
		wr(ADDR_CTRL, 8'h80);
		// match returns in the very cycle a weekday flag clear is written
		@(posedge ref_clk);
		cur_minute <= 8'h7F;
		cyc(3);
		cur_minute <= mn;
		reg_addr <= ADDR_STAT;
		reg_wdata <= 8'hFD;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		rd(ADDR_STAT, 8'h03);
		chk(1, 8'h01);
		wr(ADDR_CTRL, 8'h81);
		chk(1, 8'h00);
		wr(ADDR_CTRL, 8'h80);
		chk(1, 8'h01);
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_STAT, 8'h00);
		alarm_w_days <= 7'h00;
		done("weekday alarm");
		// level codes with boundary counters; second zero fires only code 100
		cur_minute <= 8'h59;
		cur_hour <= 8'h23;
		for (int i = 0; i < 8; i++) begin
			d = (i % 4 == 0 || i < 4) ? 8'h04 : 8'h00;
			cur_second <= (i < 4) ? 8'h59 : 8'h00;
			wr(ADDR_CTRL, 8'(4 + i % 4));
			sec_pulse();
			cyc(3);
			rd(ADDR_STAT, d);
			chk(1, (d != 8'h00) ? 8'h02 : 8'h03);
			wr(ADDR_STAT, 8'hFB);
			chk(1, 8'h03);
		end
		done("level codes");
		for (int c = 2; c < 4; c++) begin
			wr(ADDR_CTRL, 8'(c));
			sec_pulse();
			cyc(1);
			chk(1, 8'h02);
			cyc((c == 2 ? 8192 : 16384) - 40);
			chk(1, 8'h02);
			cyc(60);
			chk(1, 8'h03);
		end
		wait_fall();
		cyc(8);
		chk(2, 8'h01);
		done("pulse");
		wr(ADDR_CTRL, 8'h04);
		sec_pulse();
		cyc(3);
		wr(ADDR_STAT, 8'hFB);
		chk(1, 8'h03);
		wait_fall();
		cyc(8);
		chk(2, 8'h01);
		rd(ADDR_STAT, 8'h04);
		chk(1, 8'h02);
		wr(ADDR_CTRL, 8'hC1);
		osc_halt_flag <= 1'b1;
		cyc(2);
		osc_halt_flag <= 1'b0;
		rd(ADDR_CTRL, 8'h00);
		rd(ADDR_STAT, 8'h00);
		chk(1, 8'h03);
		done("level second and halt");
		finish_test();
	end
endmodule
`default_nettype wire
